// *** rtl/uls_regs.svh ***
// Notes on behaviour
// [RULE1] Status bit 7: errored char queued, read clears
// [RULE2] Bit 6: transmitter fully empty, resets to one
// [RULE3] Bit 5: transmit queue empty, several clears; code sets it only at reset
// [RULE4] Long low line: break flag, zero char
// [RULE5] Bad stop bit: framing flag, resynchronise
// [RULE6] Bad parity at queue top sets bit 2
// [RULE7] Full queue: overrun flag, new char dropped
// [RULE8] Next char after space frees overrun state
// [RULE9] Bit 0 high while receive queue nonempty
// [RULE10] Modem bits 7:4 inverted inputs or loopback
// [RULE11] Modem bits 3:0 flag changes, read clears
// [RULE12] Control bits 1:0 drive low-active pins inverted
// [RULE13] Divisor access bit remaps two low offsets
// [RULE14] Sixteen-bit divisor, zero disables serial traffic
// [RULE15] Sample ticks at sixteen times baud rate
// [RULE16] Counter restarts on low divisor byte write
// [RULE17] Software programs divisor 1 to 65535
// [RULE18] Separate sixteen-byte transmit and receive queues
// [RULE19] Three readings per bit, majority wins
// [RULE20] Start checked mid-bit, false start ignored
// [RULE21] Data bits every sixteenth tick, then parity
// [RULE22] Stop bit must be high, store char
// [RULE23] Control bits 1:0 select five to eight bits
// [RULE24] Loopback holds output high, routes internally
// [RULE25] Receiver checks only first stop bit
`ifndef ULS_REGS_SVH
`define ULS_REGS_SVH
// ==========================================================
// Register offsets
`define ULS_OFS_DATA    8'h00
`define ULS_OFS_IEN     8'h04
`define ULS_OFS_IDENT   8'h08
`define ULS_OFS_LCTRL   8'h0c
`define ULS_OFS_MCTRL   8'h10
`define ULS_OFS_LSTAT   8'h14
`define ULS_OFS_MSTAT   8'h18
// ==========================================================
// Field positions and reset values
`define ULS_LC_DLAB     7
`define ULS_LC_BREAK    6
`define ULS_LC_STICK    5
`define ULS_LC_EVEN     4
`define ULS_LC_PEN      3
`define ULS_LC_STOP2    2
`define ULS_MC_LOOP     4
`define ULS_MC_USER_OUTPUT_TWO     3
`define ULS_MC_USER_OUTPUT_ONE     2
`define ULS_MC_RTS      1
`define ULS_MC_DTR      0
`define ULS_LCTRL_RST   8'h07
`define ULS_IDENT_NONE  4'h1
// ==========================================================
// Timing and sizes
`define ULS_MID_NORM    4'h7
`define ULS_MID_IR      4'h3
`define ULS_LAST_TICK   4'hf
`define ULS_FIFO_DEPTH  16
`define ULS_RX_W        11
`endif

// *** rtl/uls_pkg.sv ***
package uls_pkg;
  // One-hot receive states
  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } uls_rx_state_t;
  // One-hot transmit states
  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } uls_tx_state_t;
endpackage : uls_pkg

// *** rtl/uls_fifo.sv ***
`timescale 1ns/100ps
module uls_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = cnt_q != DEPTH[AW:0];
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= push ? wr_q + 1'b1 : wr_q;
      rd_q  <= pop ? rd_q + 1'b1 : rd_q;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : uls_fifo

// *** rtl/uls_top.sv ***
`timescale 1ns/100ps
`include "uls_regs.svh"
module uls_top (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        infrared_mode_i,
  input  wire logic        rx_i,
  output logic             tx_o,
  input  wire logic        carrier_detect_in_n_i,
  input  wire logic        ring_indicator_in_n_i,
  input  wire logic        set_ready_in_n_i,
  input  wire logic        clear_to_send_in_n_i,
  output logic             request_to_send_out_n_o,
  output logic             terminal_ready_out_n_o
);
  import uls_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : hit

  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : maj3

  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [7:0] lc);
    logic [7:0] m;
    unique case (lc[1:0])
      2'h0: m = 8'h1f;
      2'h1: m = 8'h3f;
      2'h2: m = 8'h7f;
      2'h3: m = 8'hff;
    endcase
    if (lc[`ULS_LC_STICK]) return ~lc[`ULS_LC_EVEN];
    return lc[`ULS_LC_EVEN] ? ^(d & m) : ~^(d & m);
  endfunction : par_bit

  // ==========================================================
  // Register bus, one wait state per access
  logic        acc, wr, rd, dlab;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q, mapped;
  logic [7:0]  dll_q, dlh_q, lctrl_q;
  logic [4:0]  mctrl_q;
  logic [3:0]  ien_q;
  logic [15:0] divisor;
  logic        dll_wr, dlh_wr, thr_wr, rbr_rd, lsr_rd, iir_rd, msr_rd;

  assign acc     = psel_i && penable_i && !pready_q;
  assign wr      = acc && pwrite_i;
  assign rd      = acc && !pwrite_i;
  assign dlab    = lctrl_q[`ULS_LC_DLAB];
  assign divisor = {dlh_q, dll_q};                  // see [RULE14]
  assign dll_wr  = wr && dlab && hit(paddr_i, `ULS_OFS_DATA); // see [RULE13]
  assign dlh_wr  = wr && dlab && hit(paddr_i, `ULS_OFS_IEN);
  assign thr_wr  = wr && !dlab && hit(paddr_i, `ULS_OFS_DATA);
  assign rbr_rd  = rd && !dlab && hit(paddr_i, `ULS_OFS_DATA);
  assign lsr_rd  = rd && hit(paddr_i, `ULS_OFS_LSTAT);
  assign iir_rd  = rd && hit(paddr_i, `ULS_OFS_IDENT);
  assign msr_rd  = rd && hit(paddr_i, `ULS_OFS_MSTAT);
  assign mapped  = paddr_i <= `ULS_OFS_MSTAT && paddr_i[1:0] == 2'h0;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dll_q   <= 8'h00;
      dlh_q   <= 8'h00;
      lctrl_q <= `ULS_LCTRL_RST;                    // see [RULE23]
      mctrl_q <= 5'h00;
      ien_q   <= 4'h0;
    end else if (wr) begin
      if (dll_wr) dll_q <= pwdata_i[7:0];
      if (dlh_wr) dlh_q <= pwdata_i[7:0];
      if (!dlab && hit(paddr_i, `ULS_OFS_IEN)) ien_q <= pwdata_i[3:0];
      if (hit(paddr_i, `ULS_OFS_LCTRL)) lctrl_q <= pwdata_i[7:0];
      if (hit(paddr_i, `ULS_OFS_MCTRL)) mctrl_q <= pwdata_i[4:0];
    end
  end

  // ==========================================================
  // Status flags
  logic [7:0]  line_status_reg;
  logic [7:0]  msr_hi_q;
  logic [3:0]  delta_q;
  logic [3:0]  ident;
  logic        err_q, temt_q, thre_q, brk_q, fe_q, pe_q, oe_q;
  logic        rx_in_ready, rx_out_valid, rx_push, rx_pop, top_new_q;
  logic        tx_in_ready, tx_out_valid, tx_pop, tx_idle, tx_empty_q;
  logic [10:0] rx_word, rx_top;
  logic [7:0]  tx_top;

  assign line_status_reg = {err_q, temt_q, thre_q, brk_q, fe_q, pe_q, oe_q,
                rx_out_valid};                      // see [RULE9]

  always_comb begin
    if (ien_q[2] && (oe_q || pe_q || fe_q || brk_q)) ident = 4'h6;
    else if (ien_q[0] && rx_out_valid) ident = 4'h4;
    else if (ien_q[1] && thre_q) ident = 4'h2;      // see [RULE3]
    else if (ien_q[3] && delta_q != 4'h0) ident = 4'h0;
    else ident = `ULS_IDENT_NONE;
  end

  always_comb begin
    rdata_d = 32'h0;
    unique case (1'b1)
      hit(paddr_i, `ULS_OFS_DATA):
        rdata_d[7:0] = dlab ? dll_q : (rx_out_valid ? rx_top[7:0] : 8'h00);
      hit(paddr_i, `ULS_OFS_IEN):
        rdata_d[7:0] = dlab ? dlh_q : {4'h0, ien_q};
      hit(paddr_i, `ULS_OFS_IDENT): rdata_d[7:0] = {4'hc, ident};
      hit(paddr_i, `ULS_OFS_LCTRL): rdata_d[7:0] = lctrl_q;
      hit(paddr_i, `ULS_OFS_MCTRL): rdata_d[7:0] = {3'h0, mctrl_q};
      hit(paddr_i, `ULS_OFS_LSTAT): rdata_d[7:0] = line_status_reg;
      hit(paddr_i, `ULS_OFS_MSTAT): rdata_d[7:0] = {msr_hi_q[3:0], delta_q};
      default: rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      if (rd) prdata_q <= rdata_d;
    end
  end

  // Set wins over a read clear landing in the same cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
      brk_q <= 1'b0;
      fe_q  <= 1'b0;
      pe_q  <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      err_q <= (rx_push && rx_in_ready && rx_word[10:8] != 3'h0)
               || (err_q && !lsr_rd);               // see [RULE1]
      brk_q <= (top_new_q && rx_out_valid && rx_top[10])
               || (brk_q && !lsr_rd);               // see [RULE4]
      fe_q  <= (top_new_q && rx_out_valid && rx_top[9])
               || (fe_q && !lsr_rd);                // see [RULE5]
      pe_q  <= (top_new_q && rx_out_valid && rx_top[8])
               || (pe_q && !lsr_rd);                // see [RULE6]
      // A dropped char sets, a stored one leaves the overrun state
      oe_q  <= (rx_push && !rx_in_ready)            // see [RULE7]
               || (oe_q && !lsr_rd && !(rx_push && rx_in_ready)); // see [RULE8]
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      thre_q     <= 1'b1;
      temt_q     <= 1'b1;
      tx_empty_q <= 1'b1;
      top_new_q  <= 1'b0;
    end else begin
      tx_empty_q <= !tx_out_valid && tx_idle;
      top_new_q  <= rx_pop || (rx_push && rx_in_ready && !rx_out_valid);
      thre_q <= (!tx_out_valid && tx_pop)
                || (thre_q && !lsr_rd && !iir_rd && !thr_wr); // see [RULE3]
      temt_q <= (!tx_out_valid && tx_idle && !tx_empty_q)
                || (temt_q && !lsr_rd && !thr_wr);  // see [RULE2]
    end
  end

  // ==========================================================
  // Pin synchronisers and modem lines
  logic [4:0] sync1_q, sync2_q;
  logic [3:0] msr_hi_d;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
    end else begin
      sync1_q <= {rx_i, carrier_detect_in_n_i, ring_indicator_in_n_i,
                  set_ready_in_n_i, clear_to_send_in_n_i};
      sync2_q <= sync1_q;
    end
  end

  assign msr_hi_d = mctrl_q[`ULS_MC_LOOP]
    ? {mctrl_q[`ULS_MC_USER_OUTPUT_TWO], mctrl_q[`ULS_MC_USER_OUTPUT_ONE],
       mctrl_q[`ULS_MC_DTR], mctrl_q[`ULS_MC_RTS]}
    : ~sync2_q[3:0];                                // see [RULE10]

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      msr_hi_q <= 8'h00;
      delta_q  <= 4'h0;
    end else begin
      msr_hi_q <= {4'h0, msr_hi_d};
      delta_q  <= (msr_hi_d ^ msr_hi_q[3:0])
                  | (delta_q & {4{!msr_rd}});       // see [RULE11]
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      request_to_send_out_n_o <= 1'b1;
      terminal_ready_out_n_o  <= 1'b1;
    end else begin
      request_to_send_out_n_o <= ~mctrl_q[`ULS_MC_RTS]; // see [RULE12]
      terminal_ready_out_n_o  <= ~mctrl_q[`ULS_MC_DTR];
    end
  end

  AST_RTS_PIN: // see [RULE12]
  assert property (@(posedge clock_i) disable iff (rst_i)
    ##1 request_to_send_out_n_o == !$past(mctrl_q[`ULS_MC_RTS]))
    else $error("request to send pin not inverse of control bit");

  AST_MODEM_DELTA: // see [RULE11]
  assert property (@(posedge clock_i) disable iff (rst_i)
    (msr_hi_d != msr_hi_q[3:0]) |=> (delta_q != 4'h0))
    else $error("modem line change not flagged");

  // ==========================================================
  // Baud tick generation
  logic [15:0] baud_cnt_q;
  logic        tick_q;
  logic [3:0]  txdiv_q;
  logic        bit_en;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      baud_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else if (dll_wr) begin                      // see [RULE16]
      baud_cnt_q <= {dlh_q, pwdata_i[7:0]};
      tick_q     <= 1'b0;
    end else if (divisor == 16'h0000) begin         // see [RULE14] [RULE17]
      tick_q     <= 1'b0;
    end else if (baud_cnt_q <= 16'h0001) begin      // see [RULE15]
      baud_cnt_q <= divisor;
      tick_q     <= 1'b1;
    end else begin
      baud_cnt_q <= baud_cnt_q - 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) txdiv_q <= 4'h0;
    else if (tick_q) txdiv_q <= txdiv_q + 4'h1;
  end
  assign bit_en = tick_q && txdiv_q == `ULS_LAST_TICK; // see [RULE15]

  AST_ZERO_DIVISOR: // see [RULE14]
  assert property (@(posedge clock_i) disable iff (rst_i)
    (divisor == 16'h0000) |=> !tick_q)
    else $error("sample tick with zero divisor");

  AST_TICK_SPACING: // see [RULE15]
  assert property (@(posedge clock_i) disable iff (rst_i)
    (tick_q && divisor > 16'h0001 && !dll_wr && !dlh_wr) |=> !tick_q)
    else $error("sample ticks too close for divisor");

  // ==========================================================
  // Transmitter
  uls_tx_state_t tx_state_q;
  logic [7:0]    tx_sh_q;
  logic [2:0]    tx_bit_q;
  logic          tx_stop_q, tx_line;
  logic [2:0]    last_bit;

  assign last_bit = {1'b0, lctrl_q[1:0]} + 3'h4;   // see [RULE23]
  assign tx_idle  = tx_state_q == TX_IDLE;
  assign tx_pop   = tx_idle && tx_out_valid;        // see [RULE18]

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_q <= TX_IDLE;
      tx_sh_q    <= 8'h00;
      tx_bit_q   <= 3'h0;
      tx_stop_q  <= 1'b0;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: if (tx_pop) begin
          tx_sh_q    <= tx_top;
          tx_state_q <= TX_START;
        end
        TX_START: if (bit_en) begin
          tx_bit_q   <= 3'h0;
          tx_state_q <= TX_DATA;
        end
        TX_DATA: if (bit_en) begin
          tx_bit_q <= tx_bit_q + 3'h1;
          if (tx_bit_q == last_bit) begin
            tx_state_q <= lctrl_q[`ULS_LC_PEN] ? TX_PAR : TX_STOP;
            tx_stop_q  <= 1'b0;
          end
        end
        TX_PAR: if (bit_en) begin
          tx_stop_q  <= 1'b0;
          tx_state_q <= TX_STOP;
        end
        TX_STOP: if (bit_en) begin
          tx_stop_q <= 1'b1;
          if (tx_stop_q || !lctrl_q[`ULS_LC_STOP2]) tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    unique case (tx_state_q)
      TX_START: tx_line = 1'b0;
      TX_DATA:  tx_line = tx_sh_q[tx_bit_q];
      TX_PAR:   tx_line = par_bit(tx_sh_q, lctrl_q);
      default:  tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) tx_o <= 1'b1;
    else tx_o <= mctrl_q[`ULS_MC_LOOP] ||
                 (!lctrl_q[`ULS_LC_BREAK] && tx_line); // see [RULE24]
  end

  AST_LOOP_TX_HIGH: // see [RULE24]
  assert property (@(posedge clock_i) disable iff (rst_i)
    mctrl_q[`ULS_MC_LOOP] |=> tx_o)
    else $error("serial output not high in loopback");

  // ==========================================================
  // Receiver
  uls_rx_state_t rx_state_q;
  logic [3:0]    rx_cnt_q, mid_c;
  logic [2:0]    rx_bit_q;
  logic [7:0]    rx_data_q;
  logic [1:0]    hist_q;
  logic          rx_src, bit_v, perr_q, zero_q, brk_wait_q;

  // Loopback feeds the transmitter straight in, no sync needed
  assign rx_src = mctrl_q[`ULS_MC_LOOP] ? tx_line : sync2_q[4]; // see [RULE24]
  assign mid_c  = infrared_mode_i ? `ULS_MID_IR : `ULS_MID_NORM; // see [RULE20]
  assign bit_v  = maj3(hist_q[1], hist_q[0], rx_src); // see [RULE19]
  // Only the first stop bit is looked at
  assign rx_push = rx_state_q == RX_STOP && tick_q &&
                   rx_cnt_q == `ULS_LAST_TICK;      // see [RULE22] [RULE25]
  assign rx_word = {~bit_v & zero_q, ~bit_v & ~zero_q,
                    perr_q, rx_data_q};             // see [RULE4] [RULE5]

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) hist_q <= 2'h3;
    else if (tick_q) hist_q <= {hist_q[0], rx_src};
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_data_q  <= 8'h00;
      perr_q     <= 1'b0;
      zero_q     <= 1'b1;
      brk_wait_q <= 1'b0;
    end else begin
      unique case (rx_state_q)
        RX_IDLE: if (!rx_src && !brk_wait_q) begin
          rx_cnt_q   <= 4'h0;
          rx_state_q <= RX_START;
        end else if (rx_src) begin
          brk_wait_q <= 1'b0;                       // see [RULE4]
        end
        RX_START: if (tick_q) begin
          rx_cnt_q <= 4'h0;
          if (rx_cnt_q != mid_c) rx_cnt_q <= rx_cnt_q + 4'h1;
          else if (bit_v) rx_state_q <= RX_IDLE;    // see [RULE20]
          else begin
            rx_bit_q   <= 3'h0;
            rx_data_q  <= 8'h00;
            perr_q     <= 1'b0;
            zero_q     <= 1'b1;
            rx_state_q <= RX_DATA;
          end
        end
        RX_DATA: if (tick_q) begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_cnt_q == `ULS_LAST_TICK) begin     // see [RULE21]
            rx_data_q[rx_bit_q] <= bit_v;
            zero_q   <= zero_q & ~bit_v;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit)
              rx_state_q <= lctrl_q[`ULS_LC_PEN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (tick_q) begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_cnt_q == `ULS_LAST_TICK) begin
            perr_q     <= bit_v != par_bit(rx_data_q, lctrl_q); // see [RULE6]
            zero_q     <= zero_q & ~bit_v;
            rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: if (tick_q) begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_cnt_q == `ULS_LAST_TICK) begin
            if (bit_v) rx_state_q <= RX_IDLE;
            else if (zero_q) begin
              brk_wait_q <= 1'b1;                   // see [RULE4]
              rx_state_q <= RX_IDLE;
            end else begin
              // Low stop bit is taken as the next start bit
              rx_bit_q   <= 3'h0;
              rx_data_q  <= 8'h00;
              perr_q     <= 1'b0;
              zero_q     <= 1'b1;
              rx_state_q <= RX_DATA;                // see [RULE5]
            end
          end
        end
      endcase
    end
  end

  AST_FALSE_START: // see [RULE20]
  assert property (@(posedge clock_i) disable iff (rst_i)
    (rx_state_q == RX_START && tick_q && rx_cnt_q == mid_c && bit_v)
    |=> rx_state_q == RX_IDLE)
    else $error("false start bit not ignored");

  AST_OVERRUN_SET: // see [RULE7]
  assert property (@(posedge clock_i) disable iff (rst_i)
    (rx_push && !rx_in_ready) |=> oe_q ##1 (oe_q || $past(lsr_rd)))
    else $error("overrun not flagged");

  AST_DATA_READY: // see [RULE9]
  assert property (@(posedge clock_i) disable iff (rst_i)
    (rx_push && rx_in_ready) |=> line_status_reg[0])
    else $error("data ready low after store");

  // ==========================================================
  // Character queues
  assign rx_pop = rbr_rd && rx_out_valid;

  uls_fifo #(.WIDTH(`ULS_RX_W), .DEPTH(`ULS_FIFO_DEPTH)) u_rx_fifo ( // see [RULE18]
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .flush_i     (wr && !dlab && hit(paddr_i, `ULS_OFS_IDENT) && pwdata_i[1]),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (rx_word),
    .out_valid_o (rx_out_valid),
    .out_ready_i (rx_pop),
    .out_data_o  (rx_top)
  );

  uls_fifo #(.WIDTH(8), .DEPTH(`ULS_FIFO_DEPTH)) u_tx_fifo (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .flush_i     (wr && !dlab && hit(paddr_i, `ULS_OFS_IDENT) && pwdata_i[2]),
    .in_valid_i  (thr_wr),
    .in_ready_o  (tx_in_ready),
    .in_data_i   (pwdata_i[7:0]),
    .out_valid_o (tx_out_valid),
    .out_ready_i (tx_pop),
    .out_data_o  (tx_top)
  );

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;
endmodule : uls_top

// *** verification/uls_remote_dev.sv ***
`timescale 1ns/100ps
// ==========================================
// Remote sender: 8N1 frames, LSB first
module uls_remote_dev #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clock_i,
  output logic      ser_o
);
  initial ser_o = 1'h1;
  // A low stop bit makes a framing error, or a break with zero data
  task automatic send_frame(input logic [7:0] data, input logic stop);
    logic [9:0] bits;
    bits = {stop, data, 1'h0};
    for (int i = 0; i < 10; i++) begin
      ser_o = bits[i];
      repeat (BIT_CYC) @(negedge clock_i);
    end
    ser_o = 1'h1;
    repeat (2 * BIT_CYC) @(negedge clock_i);
  endtask : send_frame
endmodule : uls_remote_dev

// *** verification/tb_uls_top.sv ***
`timescale 1ns/100ps
module tb_uls_top;
  typedef struct {
    logic       wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] m;
    logic       er;
  } uls_row_t;
  logic        clock_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        psel_i = 1'h0;
  logic        penable_i = 1'h0;
  logic        pwrite_i = 1'h0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        cd_n = 1'h1;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, rx_i, tx_o, rts_n, dtr_n, er;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          n_checks = 0;
  uls_row_t    rows[10] = '{
    '{1'h0, 8'h14, 8'h00, 8'h60, 8'hff, 1'h0},
    '{1'h0, 8'h18, 8'h00, 8'h00, 8'hff, 1'h0},
    '{1'h0, 8'h0c, 8'h00, 8'h07, 8'hff, 1'h0},
    '{1'h0, 8'h1c, 8'h00, 8'h00, 8'hff, 1'h1},
    '{1'h1, 8'h0c, 8'h83, 8'h00, 8'h00, 1'h0},
    '{1'h1, 8'h04, 8'h00, 8'h00, 8'h00, 1'h0},
    '{1'h1, 8'h00, 8'h01, 8'h00, 8'h00, 1'h0},
    '{1'h0, 8'h00, 8'h00, 8'h01, 8'hff, 1'h0},
    '{1'h1, 8'h0c, 8'h03, 8'h00, 8'h00, 1'h0},
    '{1'h1, 8'h10, 8'h03, 8'h00, 8'h00, 1'h0}};

  always #5 clock_i = ~clock_i;

  uls_remote_dev rem (.clock_i(clock_i), .ser_o(rx_i));

  uls_top DUT (
    .clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_i, .tx_o,
    .infrared_mode_i(1'h0), .carrier_detect_in_n_i(cd_n),
    .ring_indicator_in_n_i(1'h1), .set_ready_in_n_i(1'h1),
    .clear_to_send_in_n_i(1'h1), .request_to_send_out_n_o(rts_n),
    .terminal_ready_out_n_o(dtr_n));

  // ==========================================
  // Checking and bus tasks
  task automatic give_verdict();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk

  // Holds the request until pready is seen, releases a cycle later
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(negedge clock_i);
    psel_i = 1'h1;
    pwrite_i = w;
    paddr_i = a;
    pwdata_i = wd;
    @(negedge clock_i);
    penable_i = 1'h1;
    n = 0;
    while (pready_o !== 1'h1 && n < 8) begin
      @(negedge clock_i);
      n++;
    end
    rd = prdata_o;
    er = pslverr_o;
    @(negedge clock_i);
    psel_i = 1'h0;
    penable_i = 1'h0;
    if (n == 8) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : apb

  task automatic rdm(input logic [7:0] a, m, e);
    apb(1'h0, a, 32'h0);
    chk("read", {24'h0, e}, rd & {24'h0, m});
  endtask : rdm

  // ==========================================
  // Sequence
  initial begin
    repeat (10) @(negedge clock_i);
    rst_i = 1'h0;
    rem.send_frame(8'h55, 1'h1);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, {24'h0, rows[i].d});
      chk("reg", {24'h0, rows[i].e}, rd & {24'h0, rows[i].m});
      chk("slverr", {31'h0, rows[i].er}, {31'h0, er});
    end
    chk("pins", 32'h0, {30'h0, rts_n, dtr_n});
    rdm(8'h14, 8'h01, 8'h00);
    rem.send_frame(8'ha5, 1'h1);
    rdm(8'h14, 8'h01, 8'h01);
    rdm(8'h00, 8'hff, 8'ha5);
    rdm(8'h14, 8'h01, 8'h00);
    rem.send_frame(8'h3c, 1'h0);
    repeat (200) @(negedge clock_i);
    rdm(8'h14, 8'h89, 8'h89);
    rdm(8'h00, 8'hff, 8'h3c);
    rdm(8'h00, 8'hff, 8'hff);
    rem.send_frame(8'h00, 1'h0);
    repeat (40) @(negedge clock_i);
    rdm(8'h14, 8'h10, 8'h10);
    rdm(8'h00, 8'hff, 8'h00);
    repeat (17) rem.send_frame(8'h11, 1'h1);
    rdm(8'h14, 8'h03, 8'h03);
    repeat (16) rdm(8'h00, 8'hff, 8'h11);
    rdm(8'h14, 8'h01, 8'h00);
    cd_n = 1'h0;
    repeat (5) @(negedge clock_i);
    rdm(8'h18, 8'hff, 8'h88);
    rdm(8'h18, 8'h0f, 8'h00);
    apb(1'h1, 8'h10, 32'h1d);
    rdm(8'h18, 8'hf0, 8'he0);
    // Loopback carries a transmitted char back into the receive queue
    apb(1'h1, 8'h00, 32'h5a);
    repeat (250) @(negedge clock_i);
    rdm(8'h00, 8'hff, 8'h5a);
    chk("tx", 32'h1, {31'h0, tx_o});
    give_verdict();
  end
endmodule : tb_uls_top
